// *** ais_map.vh ***
// register map, field positions, reset values and ranges of the scaler
// assumes 32-bit avalon data, byte addresses, word-aligned registers
`ifndef AIS_MAP_VH
`define AIS_MAP_VH

`define AIS_ADDR_W 6
`define AIS_OFS_CTRL 6'h00
`define AIS_OFS_LOW_BOUND 6'h04
`define AIS_OFS_HIGH_BOUND 6'h08
`define AIS_OFS_SCALE_SEL 6'h0C
`define AIS_OFS_SCALED_LOW 6'h10
`define AIS_OFS_SCALED_HIGH 6'h14
`define AIS_OFS_STATUS 6'h18
`define AIS_OFS_SAMPLE 6'h1C
`define AIS_OFS_PROCESS 6'h20

// ctrl fields
`define AIS_CTRL_FUNC_LSB 0
`define AIS_CTRL_RANGE_LSB 8
// scale select fields
`define AIS_SEL_LOW_LSB 0
`define AIS_SEL_HIGH_LSB 8

// function codes
`define AIS_FUNC_OFF 2'h0
`define AIS_FUNC_PROCESS 2'h3
// range setup codes
`define AIS_RNG_LIVE_MA 3'h0
`define AIS_RNG_FULL_MA 3'h1
`define AIS_RNG_USER_MA 3'h2
`define AIS_RNG_FULL_V 3'h4
`define AIS_RNG_LIVE_V 3'h5
`define AIS_RNG_USER_V 3'h6
// scaled-end select codes
`define AIS_SEL_MIN 2'h0
`define AIS_SEL_MAX 2'h1
`define AIS_SEL_USER 2'h2

// physical values in hundredths of mA or of V
`define AIS_PHYS_ZERO 12'h000
`define AIS_MA_LIVE_ZERO 12'h190
`define AIS_MA_FULL 12'h7D0
`define AIS_V_LIVE_ZERO 12'h0C8
`define AIS_V_FULL 12'h3E8

// process values in thousandths, signed
`define AIS_PROC_MIN 32'hFF676980
`define AIS_PROC_MAX 32'h00989680
`define AIS_PROC_ZERO 32'h00000000

// reset values
`define AIS_RST_FUNC 2'h3
`define AIS_RST_RANGE 3'h0
`define AIS_RST_LOW_BOUND 12'h190
`define AIS_RST_HIGH_BOUND 12'h7D0
`define AIS_RST_SEL_LOW 2'h0
`define AIS_RST_SEL_HIGH 2'h1

`endif

// *** ais_scaler.v ***
// analogue input scaler: range setup, bounds, scaling and avalon slave
// assumes a sampled input in hundredths of mA or V, and a jumper pin
//
// What this block does
// [RULE1] function code 0 inactive, code 3 gives a usable process value
// [RULE2] raw input reaches the comparator output even when inactive
// [RULE3] range 0 is current with fixed 4 mA live zero to full scale
// [RULE4] range 1 full current scale, range 4 full voltage scale
// [RULE5] range 5 is voltage with fixed 2 V live zero to full scale
// [RULE6] ranges 2 and 6 take their ends from low and high bounds
// [RULE7] jumper allows only current or only voltage range codes
// [RULE8] jumper change never rewrites the stored range setup
// [RULE9] bound unit follows the range: mA for current, V for voltage
// [RULE10] low bound only in user ranges, 0..20 mA or 0..10 V
// [RULE11] high bound only in user ranges, same limits, full-scale default
// [RULE12] low bound above high bound inverts the input
// [RULE13] scaled-low select: 0 minimum, 1 maximum, 2 user value
// [RULE14] scaled-high select: 0 minimum, 1 maximum, 2 user value
// [RULE15] user scaled values used only on code 2, +-10000.000, default 0
// [RULE16] process value interpolates linearly between scaled ends
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
`include "ais_map.vh"

module ais_scaler
(
  mclk,
  reset_n,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  rangeJumper,
  inputSample,
  comparatorSample,
  processValue,
  processValid,
  unitVolt
);
  parameter SAMPLE_W = 12;

  input wire mclk;
  input wire reset_n;
  input wire [`AIS_ADDR_W-1:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  input wire [3:0] avs_byteenable;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;
  input wire rangeJumper;
  input wire [SAMPLE_W-1:0] inputSample;
  output reg [SAMPLE_W-1:0] comparatorSample;
  output reg [31:0] processValue;
  output reg processValid;
  output reg unitVolt;

  ////////////////////////////////////////////////////////////////////////
  // functions

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = be[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // scaled end selection shared by both ends
  function [31:0] pickEnd;
    input [1:0] sel;
    input [31:0] user;
    begin
      if (sel == `AIS_SEL_MIN)
        pickEnd = `AIS_PROC_MIN;
      else if (sel == `AIS_SEL_MAX)
        pickEnd = `AIS_PROC_MAX;
      else if (sel == `AIS_SEL_USER)
        pickEnd = user;
      else
        pickEnd = `AIS_PROC_ZERO;
    end
  endfunction

  function isVoltRange;
    input [2:0] code;
    begin
      isVoltRange = (code == `AIS_RNG_FULL_V) ||
                    (code == `AIS_RNG_LIVE_V) ||
                    (code == `AIS_RNG_USER_V);
    end
  endfunction

  function isCurrRange;
    input [2:0] code;
    begin
      isCurrRange = (code == `AIS_RNG_LIVE_MA) ||
                    (code == `AIS_RNG_FULL_MA) ||
                    (code == `AIS_RNG_USER_MA);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // sample bus is assumed slow against mclk; a torn word lasts one cycle

  reg jumperMeta_r, jumperSync_r;
  reg [SAMPLE_W-1:0] sampleMeta_r, sampleSync_r;
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      jumperMeta_r <= 1'b0;
      jumperSync_r <= 1'b0;
      sampleMeta_r <= {SAMPLE_W{1'b0}};
      sampleSync_r <= {SAMPLE_W{1'b0}};
    end
    else
    begin
      jumperMeta_r <= rangeJumper;
      jumperSync_r <= jumperMeta_r;
      sampleMeta_r <= inputSample;
      sampleSync_r <= sampleMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  reg [1:0] funcSel_r, lowSel_r, highSel_r;
  reg [2:0] rangeSetup_r;
  reg [11:0] lowBound_r, highBound_r;
  reg [31:0] scaledLow_r, scaledHigh_r;
  wire busWrite, rangeOk, userRange;
  wire [31:0] ctrlNew, lowNew, highNew, selNew, ctrlOld, selOld;
  wire [2:0] rangeReq;
  wire [11:0] boundLimit;

  assign busWrite = avs_write && !avs_waitrequest;
  assign ctrlOld = {21'h000000, rangeSetup_r, 6'h00, funcSel_r};
  assign selOld = {22'h000000, highSel_r, 6'h00, lowSel_r};
  assign ctrlNew = merge(ctrlOld, avs_writedata, avs_byteenable);
  assign selNew = merge(selOld, avs_writedata, avs_byteenable);
  assign lowNew = merge({20'h00000, lowBound_r}, avs_writedata,
                        avs_byteenable);
  assign highNew = merge({20'h00000, highBound_r}, avs_writedata,
                         avs_byteenable);
  assign rangeReq = ctrlNew[`AIS_CTRL_RANGE_LSB +: 3];
  // jumper high means voltage
  assign rangeOk = jumperSync_r ? isVoltRange(rangeReq) :
                   isCurrRange(rangeReq); // see [RULE7]
  assign userRange = (rangeSetup_r == `AIS_RNG_USER_MA) ||
                     (rangeSetup_r == `AIS_RNG_USER_V);
  assign boundLimit = isVoltRange(rangeSetup_r) ? `AIS_V_FULL :
                      `AIS_MA_FULL; // see [RULE9]

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      funcSel_r <= `AIS_RST_FUNC;
      rangeSetup_r <= `AIS_RST_RANGE;
      lowBound_r <= `AIS_RST_LOW_BOUND;
      highBound_r <= `AIS_RST_HIGH_BOUND;
      lowSel_r <= `AIS_RST_SEL_LOW;
      highSel_r <= `AIS_RST_SEL_HIGH;
      scaledLow_r <= `AIS_PROC_ZERO;
      scaledHigh_r <= `AIS_PROC_ZERO;
    end
    else if (busWrite)
    begin
      if (avs_address == `AIS_OFS_CTRL)
      begin
        if (ctrlNew[1:0] == `AIS_FUNC_OFF ||
            ctrlNew[1:0] == `AIS_FUNC_PROCESS)
          funcSel_r <= ctrlNew[1:0]; // see [RULE1]
        // stored code is only touched by software, never by the jumper
        if (rangeOk)
          rangeSetup_r <= rangeReq; // see [RULE7] see [RULE8]
      end
      else if (avs_address == `AIS_OFS_LOW_BOUND)
      begin
        if (userRange && lowNew[31:12] == 20'h00000 &&
            lowNew[11:0] <= boundLimit)
          lowBound_r <= lowNew[11:0]; // see [RULE10]
      end
      else if (avs_address == `AIS_OFS_HIGH_BOUND)
      begin
        if (userRange && highNew[31:12] == 20'h00000 &&
            highNew[11:0] <= boundLimit)
          highBound_r <= highNew[11:0]; // see [RULE11]
      end
      else if (avs_address == `AIS_OFS_SCALE_SEL)
      begin
        if (selNew[1:0] <= `AIS_SEL_USER)
          lowSel_r <= selNew[1:0]; // see [RULE13]
        if (selNew[9:8] <= `AIS_SEL_USER)
          highSel_r <= selNew[9:8]; // see [RULE14]
      end
      else if (avs_address == `AIS_OFS_SCALED_LOW)
      begin
        if ($signed(avs_writedata) >= $signed(`AIS_PROC_MIN) &&
            $signed(avs_writedata) <= $signed(`AIS_PROC_MAX))
          scaledLow_r <= avs_writedata; // see [RULE15]
      end
      else if (avs_address == `AIS_OFS_SCALED_HIGH)
      begin
        if ($signed(avs_writedata) >= $signed(`AIS_PROC_MIN) &&
            $signed(avs_writedata) <= $signed(`AIS_PROC_MAX))
          scaledHigh_r <= avs_writedata; // see [RULE15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // physical span and interpolation

  reg [11:0] physLow, physHigh;
  always @*
  begin
    physLow = `AIS_PHYS_ZERO;
    physHigh = `AIS_MA_FULL;
    case (rangeSetup_r)
      `AIS_RNG_LIVE_MA:
      begin
        physLow = `AIS_MA_LIVE_ZERO; // see [RULE3]
        physHigh = `AIS_MA_FULL;
      end
      `AIS_RNG_FULL_MA:
      begin
        physLow = `AIS_PHYS_ZERO; // see [RULE4]
        physHigh = `AIS_MA_FULL;
      end
      `AIS_RNG_FULL_V:
      begin
        physLow = `AIS_PHYS_ZERO; // see [RULE4]
        physHigh = `AIS_V_FULL;
      end
      `AIS_RNG_LIVE_V:
      begin
        physLow = `AIS_V_LIVE_ZERO; // see [RULE5]
        physHigh = `AIS_V_FULL;
      end
      `AIS_RNG_USER_MA, `AIS_RNG_USER_V:
      begin
        physLow = lowBound_r; // see [RULE6]
        physHigh = highBound_r;
      end
      default:
        physLow = `AIS_PHYS_ZERO;
    endcase
  end

  wire [31:0] endLow, endHigh, pvNxt;
  wire signed [12:0] dx, span;
  wire signed [32:0] dy;
  wire signed [46:0] prod, quot;
  assign endLow = pickEnd(lowSel_r, scaledLow_r); // see [RULE13]
  assign endHigh = pickEnd(highSel_r, scaledHigh_r); // see [RULE14]
  assign dx = $signed({1'b0, sampleSync_r[11:0]}) - $signed({1'b0, physLow});
  // a negative span turns the slope round: inverted input
  assign span = $signed({1'b0, physHigh}) -
                $signed({1'b0, physLow}); // see [RULE12]
  assign dy = $signed({endHigh[31], endHigh}) - $signed({endLow[31], endLow});
  assign prod = dx * dy;
  // one wide divider; traded area for a single-cycle result
  assign quot = (span == 13'sd0) ? 47'sd0 : prod / span;
  assign pvNxt = endLow + quot[31:0]; // see [RULE16]

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      comparatorSample <= {SAMPLE_W{1'b0}};
      processValue <= `AIS_PROC_ZERO;
      processValid <= 1'b0;
      unitVolt <= 1'b0;
    end
    else
    begin
      comparatorSample <= sampleSync_r; // see [RULE2]
      processValue <= pvNxt;
      processValid <= (funcSel_r == `AIS_FUNC_PROCESS); // see [RULE1]
      unitVolt <= isVoltRange(rangeSetup_r); // see [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the access completes

  reg [31:0] readNxt;

  always @*
  begin
    readNxt = 32'h00000000;
    if (avs_address == `AIS_OFS_CTRL)
      readNxt = ctrlOld;
    else if (avs_address == `AIS_OFS_LOW_BOUND)
      readNxt = {20'h00000, lowBound_r};
    else if (avs_address == `AIS_OFS_HIGH_BOUND)
      readNxt = {20'h00000, highBound_r};
    else if (avs_address == `AIS_OFS_SCALE_SEL)
      readNxt = selOld;
    else if (avs_address == `AIS_OFS_SCALED_LOW)
      readNxt = scaledLow_r;
    else if (avs_address == `AIS_OFS_SCALED_HIGH)
      readNxt = scaledHigh_r;
    else if (avs_address == `AIS_OFS_STATUS)
      readNxt = {28'h0000000, span[12], isVoltRange(rangeSetup_r),
                 rangeOk, jumperSync_r};
    else if (avs_address == `AIS_OFS_SAMPLE)
      readNxt = {20'h00000, sampleSync_r[11:0]};
    else if (avs_address == `AIS_OFS_PROCESS)
      readNxt = processValue;
  end

  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= readNxt;
    end
  end

endmodule // ais_scaler

// *** ais_scaler_asserts.sv ***
// checker: handshake, sample path and output causes of the scaler
// assumes it is bound into ais_scaler, one clock domain
`timescale 1ns/10ps
module ais_scaler_asserts
#(
  parameter SAMPLE_W = 12
)
(
  input wire mclk,
  input wire reset_n,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [SAMPLE_W-1:0] inputSample,
  input wire [SAMPLE_W-1:0] comparatorSample,
  input wire processValid,
  input wire unitVolt
);
  reg [2:0] upCnt_r;
  // edges since release, keeps $past out of the reset span
  always @(posedge mclk)
    if (!reset_n)
      upCnt_r <= 3'h0;
    else if (upCnt_r != 3'h7)
      upCnt_r <= upCnt_r + 3'h1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wait_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  wait_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
    else $error("request not answered");
  wait_cause_a:
    assert property (!avs_waitrequest |-> $past(avs_waitrequest)
      && ($past(avs_read) || $past(avs_write)))
    else $error("answer without request");
  rdata_hold_a:
    assert property (upCnt_r >= 3'h1 && $changed(avs_readdata)
      |-> $past(avs_read))
    else $error("read data moved without read");
  cmp_follow_a:
    assert property (upCnt_r >= 3'h3
      |-> comparatorSample == $past(inputSample, 3))
    else $error("comparator sample lags wrongly");
  reset_out_a:
    assert property ($rose(reset_n) |-> avs_waitrequest && !unitVolt
      && !processValid)
    else $error("outputs not at reset level");
  valid_after_a:
    assert property ($rose(reset_n) |-> ##[1:2] processValid)
    else $error("process value not valid after reset");
  unit_cause_a:
    assert property (upCnt_r >= 3'h3 && $changed(unitVolt)
      |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("unit moved without a write");
  valid_cause_a:
    assert property (upCnt_r >= 3'h4 && $changed(processValid)
      |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("valid moved without a write");
endmodule // ais_scaler_asserts
bind ais_scaler ais_scaler_asserts #(.SAMPLE_W(SAMPLE_W)) ais_chk_i (
  .mclk(mclk), .reset_n(reset_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .inputSample(inputSample),
  .comparatorSample(comparatorSample), .processValid(processValid),
  .unitVolt(unitVolt));

// *** ais_scaler_bench.sv ***
// bench: table of range setups, then refusals and corner cases
// assumes ais_scaler with its bound checker and the sensor model
`timescale 1ns/10ps
`include "ais_map.vh"
module ais_scaler_bench;
  typedef struct packed {
    logic [2:0] rng; logic jmp; logic [11:0] lo; logic [11:0] hi;
    logic [15:0] sel; logic [31:0] uhi; logic [11:0] x;
    logic [31:0] pv; logic volt;
  } ais_row_t;
  reg mclk = 1'b0;
  reg reset_n = 1'b0;
  reg [5:0] avs_address = 6'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  reg rangeJumper = 1'b0;
  reg [11:0] level = 12'h000;
  wire [11:0] inputSample;
  wire [11:0] comparatorSample;
  wire [31:0] processValue;
  wire processValid;
  wire unitVolt;
  reg [31:0] rdata;
  ais_row_t r;
  int errCount = 0;
  int totalChecks = 0;
  // range, jumper, low, high, selects, user high, sample, value, volt
  ais_row_t rows [0:7] = '{
    '{3'h0, 1'b0, 12'h190, 12'h7D0, 16'h0100, 32'h0, 12'h190,
      32'hFF676980, 1'b0},
    '{3'h0, 1'b0, 12'h190, 12'h7D0, 16'h0100, 32'h0, 12'h4B0, 32'h0, 1'b0},
    '{3'h1, 1'b0, 12'h190, 12'h7D0, 16'h0100, 32'h0, 12'h3E8, 32'h0, 1'b0},
    '{3'h1, 1'b0, 12'h190, 12'h7D0, 16'h0001, 32'h0, 12'h1F4,
      32'h004C4B40, 1'b0},
    '{3'h4, 1'b1, 12'h190, 12'h7D0, 16'h0100, 32'h0, 12'h0FA,
      32'hFFB3B4C0, 1'b1},
    '{3'h5, 1'b1, 12'h190, 12'h7D0, 16'h0100, 32'h0, 12'h3E8,
      32'h00989680, 1'b1},
    '{3'h6, 1'b1, 12'h320, 12'h0C8, 16'h0100, 32'h0, 12'h15E,
      32'h004C4B40, 1'b1},
    '{3'h2, 1'b0, 12'h0C8, 12'h3E8, 16'h0202, 32'h00000BB8, 12'h258,
      32'h000005DC, 1'b0}};
  always #4 mclk = ~mclk;
  ais_sensor_model ais_sensor_model_i (.mclk(mclk), .level(level),
    .inputSample(inputSample));
  ais_scaler ais_scaler_i (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rangeJumper(rangeJumper),
    .inputSample(inputSample), .comparatorSample(comparatorSample),
    .processValue(processValue), .processValid(processValid),
    .unitVolt(unitVolt));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      errCount++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    errCount++;
    finish_test;
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, `AIS_OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h00000003, rdata);
    bus(1'b0, `AIS_OFS_SCALE_SEL, 32'h0);
    chk("select reset", 32'h00000100, rdata);
    bus(1'b0, `AIS_OFS_LOW_BOUND, 32'h0);
    chk("low reset", 32'h00000190, rdata);
    bus(1'b0, `AIS_OFS_HIGH_BOUND, 32'h0);
    chk("high reset", 32'h000007D0, rdata);
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      rangeJumper <= r.jmp;
      level <= r.x;
      repeat (3) @(posedge mclk);
      bus(1'b1, `AIS_OFS_CTRL, {21'h0, r.rng, 8'h03});
      bus(1'b1, `AIS_OFS_LOW_BOUND, {20'h0, r.lo});
      bus(1'b1, `AIS_OFS_HIGH_BOUND, {20'h0, r.hi});
      bus(1'b1, `AIS_OFS_SCALE_SEL, {16'h0, r.sel});
      bus(1'b1, `AIS_OFS_SCALED_HIGH, r.uhi);
      repeat (4) @(posedge mclk);
      chk("process value", r.pv, processValue);
      chk("volt unit", {31'h0, r.volt}, {31'h0, unitVolt});
      chk("sample", {20'h0, r.x}, {20'h0, comparatorSample});
    end
    $display("test table done");
    bus(1'b1, `AIS_OFS_CTRL, 32'h00000403);
    bus(1'b0, `AIS_OFS_CTRL, 32'h0);
    chk("range refused", 32'h00000203, rdata);
    rangeJumper <= 1'b1;
    repeat (4) @(posedge mclk);
    bus(1'b0, `AIS_OFS_CTRL, 32'h0);
    chk("range kept", 32'h00000203, rdata);
    chk("unit kept", 32'h0, {31'h0, unitVolt});
    bus(1'b1, `AIS_OFS_LOW_BOUND, 32'h000007D1);
    bus(1'b0, `AIS_OFS_LOW_BOUND, 32'h0);
    chk("low over", 32'h000000C8, rdata);
    bus(1'b1, `AIS_OFS_HIGH_BOUND, 32'h000007D0);
    bus(1'b0, `AIS_OFS_HIGH_BOUND, 32'h0);
    chk("high edge", 32'h000007D0, rdata);
    bus(1'b1, `AIS_OFS_SCALED_LOW, 32'h00989681);
    bus(1'b0, `AIS_OFS_SCALED_LOW, 32'h0);
    chk("scaled over", 32'h0, rdata);
    bus(1'b1, `AIS_OFS_SCALED_LOW, 32'hFF676980);
    bus(1'b0, `AIS_OFS_SCALED_LOW, 32'h0);
    chk("scaled edge", 32'hFF676980, rdata);
    bus(1'b1, `AIS_OFS_CTRL, 32'h00000200);
    level <= 12'h123;
    repeat (5) @(posedge mclk);
    chk("inactive", 32'h0, {31'h0, processValid});
    chk("cmp inactive", 32'h123, {20'h0, comparatorSample});
    bus(1'b1, `AIS_OFS_CTRL, 32'h00000201);
    bus(1'b0, `AIS_OFS_CTRL, 32'h0);
    chk("func refused", 32'h00000200, rdata);
    bus(1'b0, `AIS_OFS_SAMPLE, 32'h0);
    chk("sample read", 32'h00000123, rdata);
    bus(1'b1, `AIS_OFS_SCALE_SEL, 32'h00000303);
    bus(1'b0, `AIS_OFS_SCALE_SEL, 32'h0);
    chk("select refused", 32'h00000202, rdata);
    bus(1'b0, 6'h24, 32'h0);
    chk("unmapped", 32'h0, rdata);
    $display("test corners done");
    finish_test;
  end
endmodule // ais_scaler_bench

// *** ais_sensor_model.sv ***
// model of the process sensor feeding the scaler input
// assumes the bench sets the level; sensor output is never left open
`timescale 1ns/10ps
module ais_sensor_model
(
  input wire mclk,
  input wire [11:0] level,
  output reg [11:0] inputSample
);
  // one clock of transducer lag, so the pin only moves on the rising edge
  initial inputSample = 12'h000;
  always @(posedge mclk)
    inputSample <= level;
endmodule // ais_sensor_model
